// ==== rtl/pvst_top.sv ====
// Frame and line qualifier generator for the parallel pixel output
`timescale 1ns/1ps
`default_nettype none
`include "pvst_regs.svh"

module pvst_top
  import pvst_pkg::*;
#(
  parameter int ACTIVE_PIX  = `PVST_ACTIVE_PIX,
  parameter int ACTIVE_ROWS = `PVST_ACTIVE_ROWS,
  parameter int HBLANK_CLKS = `PVST_HBLANK_CLKS,
  parameter int VBLANK_CLKS = `PVST_VBLANK_CLKS,
  parameter int FIFO_DEPTH  = `PVST_FIFO_DEPTH
) (
  // Core clock and reset
  input  wire logic                   CLK_I,
  input  wire logic                   RST_I,
  // Core side pixel stream and control
  input  wire logic [`PVST_PIX_W-1:0] PIXEL_DATA_I,
  input  wire logic                   PIXEL_VALID_I,
  output logic                        PIXEL_READY_O,
  input  wire logic                   FRAME_ENABLE_I,
  output logic                        FRAME_BUSY_O,
  // Link clock
  input  wire logic                   MASTER_CLOCK_IN_I,
  // Parallel video output
  output logic                        PIXEL_CLOCK_OUT_O,
  output logic [`PVST_PIX_W-1:0]      PIXEL_OUT_O,
  output logic                        FRAME_QUAL_O,
  output logic                        LINE_QUAL_O
);

  // Terminal counts, each one less than the length it times
  localparam logic [15:0] PIX_M1   = 16'(ACTIVE_PIX - 1);
  localparam logic [15:0] ROWS_M1  = 16'(ACTIVE_ROWS - 1);
  localparam logic [15:0] HBL_M1   = 16'(HBLANK_CLKS - 1);
  localparam logic [15:0] VBL_M1   = 16'(VBLANK_CLKS - 1);
  localparam logic [15:0] LEAD_M1  = 16'(`PVST_FV_LEAD_CLKS - 1);
  localparam logic [15:0] TRAIL_M1 = 16'(`PVST_FV_TRAIL_CLKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer decoding

  // Frame qualifier: high in every state but vertical blanking
  function automatic logic frame_qual(input pvst_state_t st);
    return (st != PVST_VBLANK);
  endfunction

  // Line qualifier: high only while a row's pixels leave
  function automatic logic line_qual(input pvst_state_t st);
    return (st == PVST_ACTIVE);
  endfunction

  // Terminal count of the current interval reached
  function automatic logic at_last(input logic [15:0] cnt, input logic [15:0] last);
    return (cnt == last);
  endfunction

  // After a row: blanking before the next row, or the frame trail
  function automatic pvst_state_t after_row(input logic [15:0] row);
    return (row == ROWS_M1) ? PVST_TRAIL : PVST_HBLANK;
  endfunction

  pvst_link_t             lk_q, lk_d;
  pvst_core_t             co_q, co_d;
  logic [1:0]             lrst_q;
  logic                   lrst;
  logic [`PVST_PIX_W-1:0] fifo_data;
  logic                   fifo_valid;
  logic                   fifo_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Link reset: asserted at once, released on the link clock
  // Two link edges pass before release, so no link flop leaves reset mid-cycle
  always_ff @(posedge MASTER_CLOCK_IN_I or posedge RST_I) begin
    if (RST_I) begin
      lrst_q <= 2'h3;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end
  assign lrst = lrst_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pixel buffer between core and link clocks
  // Timing is the master: an empty buffer yields zero pixels, never a stall
  pvst_fifo #(
    .WIDTH (`PVST_PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i   (CLK_I),
    .wr_rst_i   (RST_I),
    .wr_data_i  (PIXEL_DATA_I),
    .wr_valid_i (PIXEL_VALID_I),
    .wr_ready_o (PIXEL_READY_O),
    .rd_clk_i   (MASTER_CLOCK_IN_I),
    .rd_rst_i   (lrst),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_comb begin
    lk_d       = lk_q;
    // Enable crosses from the core clock through two flops
    lk_d.en_s1 = FRAME_ENABLE_I;
    lk_d.en_s2 = lk_q.en_s1;
    // Count advances each edge except when held in vertical blanking, reloaded at each interval end
    lk_d.cnt   = lk_q.cnt + 16'h0001;
    unique case (lk_q.state)
      // Vertical blanking: count saturates until a frame is allowed
      PVST_VBLANK: begin
        if (lk_q.cnt >= VBL_M1) begin
          lk_d.cnt = lk_q.cnt;
          if (lk_q.en_s2) begin
            lk_d.state = PVST_LEAD;
            lk_d.cnt   = 16'h0000;
          end
        end
      end

      // Frame lead before the first row
      PVST_LEAD: begin
        if (at_last(lk_q.cnt, LEAD_M1)) begin
          lk_d.state = PVST_ACTIVE;
          lk_d.cnt   = 16'h0000;
          lk_d.row   = 16'h0000;
        end
      end

      // Active row, one pixel per link edge
      PVST_ACTIVE: begin
        if (at_last(lk_q.cnt, PIX_M1)) begin
          lk_d.cnt   = 16'h0000;
          lk_d.state = after_row(lk_q.row);
        end
      end

      // Horizontal blanking between rows
      PVST_HBLANK: begin
        if (at_last(lk_q.cnt, HBL_M1)) begin
          lk_d.state = PVST_ACTIVE;
          lk_d.cnt   = 16'h0000;
          lk_d.row   = lk_q.row + 16'h0001;
        end
      end

      // Frame trail after the last row
      PVST_TRAIL: begin
        if (at_last(lk_q.cnt, TRAIL_M1)) begin
          lk_d.state = PVST_VBLANK;
          lk_d.cnt   = 16'h0000;
        end
      end

      // Unused codes fall back to blanking
      default: begin
        lk_d.state = PVST_VBLANK;
        lk_d.cnt   = 16'h0000;
      end
    endcase
    lk_d.fv = frame_qual(lk_d.state);
    lk_d.lv = line_qual(lk_d.state);
    if (lk_d.lv && fifo_valid) begin
      lk_d.pix = fifo_data;
    end else begin
      lk_d.pix = `PVST_PIX_RESET;
    end
  end

  // A pixel leaves the buffer on every line qualifier cycle that finds it not empty
  assign fifo_pop = lk_d.lv;

  // Link state register
  always_ff @(posedge MASTER_CLOCK_IN_I or posedge lrst) begin
    if (lrst) begin
      lk_q <= '{state: PVST_VBLANK, pix: `PVST_PIX_RESET, default: '0};
    end else begin
      lk_q <= lk_d;
    end
  end

  // Qualifiers and data come straight from link flops
  // outputs move with clock fall
  assign PIXEL_OUT_O  = lk_q.pix;
  assign FRAME_QUAL_O = lk_q.fv;
  assign LINE_QUAL_O  = lk_q.lv;

  // Zero delay model; the receiver samples on this clock's rise
  // inverted master clock
  assign PIXEL_CLOCK_OUT_O = ~MASTER_CLOCK_IN_I;

  ////////////////////////////////////////////////////////////////////////////
  // Frame status back to the core clock
  // Busy lags the link frame qualifier by two core edges
  always_comb begin
    co_d       = co_q;
    co_d.fv_s1 = lk_q.fv;
    co_d.fv_s2 = co_q.fv_s1;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      co_q <= '0;
    end else begin
      co_q <= co_d;
    end
  end

  assign FRAME_BUSY_O = co_q.fv_s2;

endmodule // pvst_top

`default_nettype wire

// ==== rtl/pvst_regs.svh ====
// Timing counts and reset values for the parallel video sync timing block
// Summary of operation
// - Qualifiers and pixel data change on one edge
// - Line qualifier spans first to last valid pixel
// - Frame qualifier leads first line by 143
// - Frame qualifier trails last line by 23
// - Pixel clock out is inverted master clock
// - Outputs change at pixel clock falling edge
`ifndef PVST_REGS_SVH
`define PVST_REGS_SVH

// Frame geometry in pixel clock periods
`define PVST_ACTIVE_PIX   752
`define PVST_ACTIVE_ROWS  480
`define PVST_HBLANK_CLKS  94
`define PVST_VBLANK_CLKS  45
`define PVST_FV_LEAD_CLKS 143
`define PVST_FV_TRAIL_CLKS 23

// Field sizes and reset values
`define PVST_PIX_W        10
`define PVST_CNT_W        16
`define PVST_FIFO_DEPTH   8
`define PVST_PIX_RESET    10'h000

`endif

// ==== rtl/pvst_pkg.sv ====
// Types shared by the parallel video sync timing block
package pvst_pkg;

  // Link sequencer states, Gray coded from blanking through the rows; entering and leaving the trail changes two bits
  typedef enum logic [2:0] {
    PVST_VBLANK = 3'h0,
    PVST_LEAD   = 3'h1,
    PVST_ACTIVE = 3'h3,
    PVST_HBLANK = 3'h2,
    PVST_TRAIL  = 3'h6
  } pvst_state_t;

  // Link domain state
  typedef struct packed {
    pvst_state_t  state;
    logic [15:0]  cnt;
    logic [15:0]  row;
    logic         en_s1;
    logic         en_s2;
    logic         fv;
    logic         lv;
    logic [9:0]   pix;
  } pvst_link_t;

  // Core domain state
  typedef struct packed {
    logic fv_s1;
    logic fv_s2;
  } pvst_core_t;

endpackage

// ==== rtl/pvst_fifo.sv ====
// Dual clock pixel FIFO with Gray coded pointers
`timescale 1ns/1ps
`default_nettype none

module pvst_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Write side
  input  wire logic             wr_clk_i,
  input  wire logic             wr_rst_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  // Read side
  input  wire logic             rd_clk_i,
  input  wire logic             rd_rst_i,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } pvst_ptr_t;

  pvst_ptr_t        w_q, w_d, r_q, r_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             full, empty, push, pop;
  logic [AW:0]      w_bin_nx, r_bin_nx;

  ////////////////////////////////////////////////////////////////////////////
  // Write domain
  assign full       = (w_q.gray == {~w_q.s2[AW:AW-1], w_q.s2[AW-2:0]});
  assign wr_ready_o = ~full;
  assign push       = wr_valid_i & ~full;
  assign w_bin_nx   = w_q.bin + (AW+1)'(push);

  always_comb begin
    w_d      = w_q;
    w_d.bin  = w_bin_nx;
    w_d.gray = w_bin_nx ^ (w_bin_nx >> 1);
    w_d.s1   = r_q.gray;
    w_d.s2   = w_q.s1;
  end

  always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
    if (wr_rst_i) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (push) begin
      mem_q[w_q.bin[AW-1:0]] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read domain
  assign empty      = (r_q.gray == r_q.s2);
  assign rd_valid_o = ~empty;
  assign rd_data_o  = mem_q[r_q.bin[AW-1:0]];
  assign pop        = rd_ready_i & ~empty;
  assign r_bin_nx   = r_q.bin + (AW+1)'(pop);

  always_comb begin
    r_d      = r_q;
    r_d.bin  = r_bin_nx;
    r_d.gray = r_bin_nx ^ (r_bin_nx >> 1);
    r_d.s1   = w_q.gray;
    r_d.s2   = r_q.s1;
  end

  always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
    if (rd_rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule // pvst_fifo

`default_nettype wire

// ==== sim/pvst_top_assertions.sv ====
// Checker for the video timing outputs
`timescale 1ns/1ps
`default_nettype none
module pvst_chk #(parameter int ACTIVE_PIX = 8) (
  // Clocks and reset
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       MASTER_CLOCK_IN_I,
  // Video output
  input wire logic       PIXEL_CLOCK_OUT_O,
  input wire logic [9:0] PIXEL_OUT_O,
  input wire logic       FRAME_QUAL_O,
  input wire logic       LINE_QUAL_O
);
  wire [11:0] vid = {PIXEL_OUT_O, FRAME_QUAL_O, LINE_QUAL_O};
  sequence s_lead;
    ##143 $rose(LINE_QUAL_O);
  endsequence
  chk_edge_align: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(vid) |-> $rose(MASTER_CLOCK_IN_I)) else $error("output moved off link edge");
  chk_pclk_fall: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(vid) |-> $fell(PIXEL_CLOCK_OUT_O)) else $error("output moved off pclk fall");
  chk_clock_inv: assert property (@(posedge CLK_I) disable iff (RST_I)
    PIXEL_CLOCK_OUT_O != MASTER_CLOCK_IN_I) else $error("pixel clock not inverted");
  chk_lead_count: assert property (@(posedge MASTER_CLOCK_IN_I) disable iff (RST_I)
    $rose(FRAME_QUAL_O) |-> s_lead) else $error("frame lead wrong");
  chk_trail_count: assert property (@(posedge MASTER_CLOCK_IN_I) disable iff (RST_I)
    $fell(FRAME_QUAL_O) |-> $past(LINE_QUAL_O, 24) && !$past(LINE_QUAL_O, 23))
    else $error("frame trail wrong");
  chk_line_len: assert property (@(posedge MASTER_CLOCK_IN_I) disable iff (RST_I)
    $rose(LINE_QUAL_O) |-> ##ACTIVE_PIX $fell(LINE_QUAL_O)) else $error("line length wrong");
  chk_pix_idle: assert property (@(posedge MASTER_CLOCK_IN_I) disable iff (RST_I)
    !LINE_QUAL_O |-> PIXEL_OUT_O == 10'h000) else $error("data outside line");
  chk_line_frame: assert property (@(posedge MASTER_CLOCK_IN_I) disable iff (RST_I)
    LINE_QUAL_O |-> FRAME_QUAL_O) else $error("line outside frame");
endmodule // pvst_chk
bind pvst_top pvst_chk #(.ACTIVE_PIX(ACTIVE_PIX)) u_pvst_chk (.CLK_I, .RST_I,
  .MASTER_CLOCK_IN_I, .PIXEL_CLOCK_OUT_O, .PIXEL_OUT_O, .FRAME_QUAL_O, .LINE_QUAL_O);
`default_nettype wire

// ==== sim/pvst_rx.sv ====
// Capture receiver model for the parallel video output
`timescale 1ns/1ps
`default_nettype none
module pvst_rx (
  // Video input
  input  wire logic       pclk_i,
  input  wire logic       fq_i,
  input  wire logic       lq_i,
  input  wire logic [9:0] pix_i,
  // Captured pixel
  output logic [9:0]      pix_o,
  output logic            vld_o
);
  always @(posedge pclk_i) begin
    vld_o <= lq_i & fq_i;
    pix_o <= pix_i;
  end
endmodule // pvst_rx
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the video timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk = 0, mclk = 0, rst = 1, vld = 0, en = 0, run = 0;
  logic [9:0] dat = 10'h000;
  wire        rdy, busy, pclk, fq, lq, cvld;
  wire  [9:0] pix, cpix;
  logic [9:0] q[$];
  int         n_fail = 0, num_checks = 0, cyc = 0, npix = 0;
  always #2.5 clk = ~clk;
  initial begin
    #1.3;
    forever #15 mclk = ~mclk;
  end
  pvst_top #(.ACTIVE_PIX(8), .ACTIVE_ROWS(2), .HBLANK_CLKS(4), .VBLANK_CLKS(4)) u_pvst_top (
    .CLK_I(clk), .RST_I(rst), .PIXEL_DATA_I(dat), .PIXEL_VALID_I(vld), .PIXEL_READY_O(rdy),
    .FRAME_ENABLE_I(en), .FRAME_BUSY_O(busy), .MASTER_CLOCK_IN_I(mclk),
    .PIXEL_CLOCK_OUT_O(pclk), .PIXEL_OUT_O(pix), .FRAME_QUAL_O(fq), .LINE_QUAL_O(lq));
  pvst_rx u_pvst_rx (.pclk_i(pclk), .fq_i(fq), .lq_i(lq), .pix_i(pix), .pix_o(cpix),
    .vld_o(cvld));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Random words at the falling edge
  always @(negedge clk) begin
    if (run) {vld, dat} <= 11'($urandom);
    else vld <= 1'b0;
  end
  // Note each accepted word
  always @(posedge clk) begin
    if (vld && rdy === 1'b1) q.push_back(dat);
  end
  // Empty FIFO yields zero pixels
  always @(negedge pclk) begin
    if (cvld === 1'b1) begin
      chk(cpix, q.size() > 0 ? q.pop_front() : 10'h000);
      npix++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h508C));
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 0;
    run = 1;
    repeat (300) @(negedge clk);
    chk({9'h000, fq}, 10'h000);
    en = 1;
    @(posedge fq);
    repeat (20) @(negedge clk);
    chk({9'h000, busy}, 10'h001);
    @(negedge fq);
    @(negedge fq);
    run = 0;
    @(negedge fq);
    chk(10'(npix), 10'h030);
    summarize();
  end
endmodule // testbench
`default_nettype wire
